/* common/etc_pkg.sv */
// Constants, register map and types of the 8-bit timer/event counter.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM slave port.
//
// Functional notes
// - Set/reset level bits ignored in PWM mode.
// - PWM compare read may precede its transfer.
// - Start is asynchronous to count clock.
// - Pin level follows timer output enable and latch; port mode sets the output enable.
// - Non-PWM mode: match clears and restarts counter.
package etc_pkg;

  // ----------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------
  localparam logic [4:0] ETC_OFS_CLK_SEL = 5'h00;
  localparam logic [4:0] ETC_OFS_MODE = 5'h04;
  localparam logic [4:0] ETC_OFS_COMPARE = 5'h08;
  localparam logic [4:0] ETC_OFS_COUNT = 5'h0c;
  localparam logic [4:0] ETC_OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] ETC_OFS_IRQ_MASK = 5'h14;
  localparam logic [4:0] ETC_OFS_PORT = 5'h18;

  // ----------------------------------------------------------------
  // Field layouts and reset values.
  // ----------------------------------------------------------------
  localparam int ETC_SEL_W = 3;
  localparam logic [2:0] ETC_SEL_EXT = 3'h0;
  localparam logic [2:0] ETC_SEL_ONE = 3'h1;
  localparam logic [7:0] ETC_CNT_TOP = 8'hff;
  localparam logic [7:0] ETC_CMP_RST = 8'h00;
  localparam logic [7:0] ETC_CNT_RST = 8'h00;
  localparam logic [6:0] ETC_PRE_RST = 7'h00;
  localparam int ETC_IRQ_MATCH = 0;
  localparam int ETC_IRQ_OVF = 1;
  localparam int ETC_PORT_MODE_BIT = 0;
  localparam int ETC_PORT_LATCH_BIT = 1;

  typedef struct packed {
    logic count_enable_bit;
    logic operation_mode_bit;
    logic [1:0] rsvd;
    logic out_ff_set_level;
    logic out_ff_reset_level;
    logic output_mode_bit;
    logic timer_output_enable;
  } etc_mode_type;

  localparam etc_mode_type ETC_MODE_RST = '0;

endpackage

/* hdl/etc_timer.sv */
// 8-bit timer/event counter with compare, output flip-flop and PWM.
// Assumes one 40 MHz clock, an Avalon-MM slave port and an event pin.
`timescale 1ns/10ps
`default_nettype none

module etc_timer
  import etc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EVENT_IN,
  output logic TIMER_PIN_O,
  output logic TIMER_PIN_OE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Bus handshake.
  // ----------------------------------------------------------------
  logic req;
  logic ack_q;
  logic wr_go;
  logic lane0;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign wr_go = AVS_WRITE & ack_q;
  assign lane0 = AVS_BYTEENABLE[0];
  assign AVS_READDATA = rdata_q;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  logic [ETC_SEL_W-1:0] sel_q;
  etc_mode_type mode_q;
  etc_mode_type mode_wr;
  logic [7:0] cmp_buf_q;
  logic [7:0] cmp_act_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] port_q;
  logic [7:0] cnt_q;
  logic out_q;
  logic pin_q;
  logic [1:0] irq_set;

  assign mode_wr = etc_mode_type'(AVS_WRITEDATA[7:0]);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sel_q <= ETC_SEL_EXT;
      mode_q <= ETC_MODE_RST;
      irq_mask_q <= 2'h0;
      port_q <= 2'h0;
    end else if (wr_go && lane0) begin
      case (AVS_ADDRESS)
        ETC_OFS_CLK_SEL: sel_q <= AVS_WRITEDATA[ETC_SEL_W-1:0];
        ETC_OFS_MODE: mode_q <= mode_wr;
        ETC_OFS_IRQ_MASK: irq_mask_q <= AVS_WRITEDATA[1:0];
        ETC_OFS_PORT: port_q <= AVS_WRITEDATA[1:0];
        default: begin
        end
      endcase
    end
  end

  // Compare buffer takes writes at once; the active value follows it.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cmp_buf_q <= ETC_CMP_RST;
    end else if (wr_go && lane0 && AVS_ADDRESS == ETC_OFS_COMPARE) begin
      cmp_buf_q <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (AVS_READ && !ack_q) begin
      case (AVS_ADDRESS)
        ETC_OFS_CLK_SEL: rdata_d[ETC_SEL_W-1:0] = sel_q;
        ETC_OFS_MODE: rdata_d[7:0] = mode_q;
        ETC_OFS_COMPARE: rdata_d[7:0] = cmp_buf_q;
        ETC_OFS_COUNT: rdata_d[7:0] = cnt_q;
        ETC_OFS_IRQ_STATUS: rdata_d[1:0] = irq_stat_q;
        ETC_OFS_IRQ_MASK: rdata_d[1:0] = irq_mask_q;
        ETC_OFS_PORT: rdata_d[1:0] = port_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Count clock selection.
  // ----------------------------------------------------------------
  logic evt_s1_q;
  logic evt_s2_q;
  logic evt_s3_q;
  logic [6:0] pre_q;
  logic [6:0] pre_mask;
  logic tick;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      evt_s1_q <= 1'b0;
      evt_s2_q <= 1'b0;
      evt_s3_q <= 1'b0;
    end else begin
      evt_s1_q <= EVENT_IN;
      evt_s2_q <= evt_s1_q;
      evt_s3_q <= evt_s2_q;
    end
  end

  // The prescaler runs free, so the first tick after start floats.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pre_q <= ETC_PRE_RST;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  assign pre_mask = 7'((8'h01 << (sel_q - ETC_SEL_ONE)) - 8'h01);
  assign tick = (sel_q == ETC_SEL_EXT) ? (evt_s2_q & ~evt_s3_q)
                                       : ((pre_q & pre_mask) == pre_mask);

  // ----------------------------------------------------------------
  // Counter, compare and output flip-flop.
  // ----------------------------------------------------------------
  logic run;
  logic pwm;
  logic match;
  logic wrap;

  assign run = mode_q.count_enable_bit;
  assign pwm = mode_q.operation_mode_bit;
  assign match = run & tick & (cnt_q == cmp_act_q);
  assign wrap = run & tick & (cnt_q == ETC_CNT_TOP);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= ETC_CNT_RST;
    end else if (!run) begin
      cnt_q <= ETC_CNT_RST;
    end else if (match && !pwm) begin
      cnt_q <= ETC_CNT_RST;
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Outside PWM or while stopped the compare is live; running in PWM it moves over at wrap.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cmp_act_q <= ETC_CMP_RST;
    end else if (!pwm || !run || wrap) begin
      cmp_act_q <= cmp_buf_q;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      out_q <= 1'b0;
    end else if (wr_go && lane0 && AVS_ADDRESS == ETC_OFS_MODE
                 && !mode_wr.operation_mode_bit
                 && (mode_wr.out_ff_set_level || mode_wr.out_ff_reset_level)) begin
      out_q <= mode_wr.out_ff_set_level;
    end else if (pwm) begin
      out_q <= run & ((cnt_q < cmp_act_q) ^ mode_q.output_mode_bit);
    end else if (match && mode_q.output_mode_bit) begin
      out_q <= ~out_q;
    end
  end

  // Pin follows the port latch; the timer drives it when enabled. Port mode only sets the output enable.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= mode_q.timer_output_enable ? out_q : port_q[ETC_PORT_LATCH_BIT];
    end
  end

  assign TIMER_PIN_O = pin_q;
  assign TIMER_PIN_OE = ~port_q[ETC_PORT_MODE_BIT];

  // ----------------------------------------------------------------
  // Interrupts.
  // ----------------------------------------------------------------
  assign irq_set[ETC_IRQ_MATCH] = match;
  assign irq_set[ETC_IRQ_OVF] = wrap;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_stat_q <= 2'h0;
    end else if (wr_go && lane0 && AVS_ADDRESS == ETC_OFS_IRQ_STATUS) begin
      irq_stat_q <= (irq_stat_q & ~AVS_WRITEDATA[1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

/* sim/etc_timer_monitor.sv */
// Assertions on the bus, interrupt and pin output enable ports of the timer.
// Assumes a bind to etc_timer from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module etc_timer_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic TIMER_PIN_OE,
  input wire logic IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  wire logic wr_done;
  assign wr_done = AVS_WRITE && !AVS_WAITREQUEST;
  a_wait_once: assert property ($rose(AVS_READ || AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait state count wrong");
  a_idle_ready: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("waitrequest high while idle");
  a_rdata_zero: assert property (!(AVS_READ && !AVS_WAITREQUEST) |-> AVS_READDATA == 32'h0)
    else $error("read data outside completion");
  a_oe_by_write: assert property ($changed(TIMER_PIN_OE) |->
    $past(wr_done) || $past(wr_done, 2)) else $error("output enable moved without write");
  a_irq_clear: assert property ($fell(IRQ) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("interrupt dropped without write");
  a_irq_idle: assert property (IRQ && !wr_done ##1 !wr_done |-> IRQ)
    else $error("interrupt not sticky");
endmodule
`default_nettype wire

/* sim/etc_timer_tb.sv */
// Self-checking bench of the 8-bit timer/event counter.
// Assumes etc_timer, etc_pkg and etc_timer_monitor.
`timescale 1ns/10ps
`default_nettype none
module etc_timer_tb import etc_pkg::*;;
  logic clk, rst, rd, wr, ev, wreq, pin, oe, irq;
  logic [4:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rdat, r;
  int errors, n_tests;
  typedef struct {logic w; logic [4:0] a; logic [7:0] d; logic [7:0] e;} etc_row_type;
  etc_row_type rows[9] = '{'{1'h0, ETC_OFS_MODE, 8'h00, 8'h00},
    '{1'h0, ETC_OFS_COUNT, 8'h00, 8'h00}, '{1'h1, 5'h1c, 8'hff, 8'h00},
    '{1'h0, 5'h1c, 8'h00, 8'h00}, '{1'h1, ETC_OFS_CLK_SEL, 8'h01, 8'h00},
    '{1'h0, ETC_OFS_CLK_SEL, 8'h00, 8'h01}, '{1'h1, ETC_OFS_COMPARE, 8'h04, 8'h00},
    '{1'h0, ETC_OFS_COMPARE, 8'h00, 8'h04}, '{1'h1, ETC_OFS_IRQ_MASK, 8'h01, 8'h00}};
  etc_timer i_dut (.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .EVENT_IN(ev), .TIMER_PIN_O(pin), .TIMER_PIN_OE(oe), .IRQ(irq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (wreq !== 1'h0);
    r = rdat;
    {rd, wr} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial begin
    {rst, rd, wr, ev, adr, be, wd} = {4'h8, 5'h00, 4'hf, 32'h0};
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("oe_rst", 32'(oe), 32'h1);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row", r, {24'h0, rows[i].e});
    end
    // ----
    // Match clears the counter and raises the interrupt.
    // ----
    bus(1'h1, ETC_OFS_MODE, 8'h02);
    bus(1'h1, ETC_OFS_MODE, 8'h03);
    bus(1'h1, ETC_OFS_MODE, 8'h83);
    repeat (12) begin
      bus(1'h0, ETC_OFS_COUNT, 8'h00);
      chk("cnt_max", 32'(r <= 32'h4), 32'h1);
    end
    chk("irq_set", 32'(irq), 32'h1);
    bus(1'h1, ETC_OFS_MODE, 8'h03);
    bus(1'h0, ETC_OFS_COUNT, 8'h00);
    chk("cnt_stop", r, 32'h0);
    bus(1'h1, ETC_OFS_IRQ_STATUS, 8'h03);
    chk("irq_clr", 32'(irq), 32'h0);
    bus(1'h1, ETC_OFS_MODE, 8'h0b);
    repeat (3) @(posedge clk);
    chk("pin_set", 32'(pin), 32'h1);
    bus(1'h1, ETC_OFS_MODE, 8'h07);
    repeat (3) @(posedge clk);
    chk("pin_reset", 32'(pin), 32'h0);
    bus(1'h1, ETC_OFS_COMPARE, 8'h00);
    bus(1'h1, ETC_OFS_MODE, 8'h40);
    bus(1'h1, ETC_OFS_MODE, 8'h41);
    bus(1'h1, ETC_OFS_MODE, 8'h49);
    @(posedge clk);
    chk("pin_pwm", 32'(pin), 32'h0);
    bus(1'h1, ETC_OFS_MODE, 8'hc9);
    bus(1'h1, ETC_OFS_COMPARE, 8'h80);
    bus(1'h0, ETC_OFS_COMPARE, 8'h00);
    chk("cmp_buf", r, 32'h80);
    bus(1'h1, ETC_OFS_MODE, 8'h49);
    bus(1'h1, ETC_OFS_MODE, 8'h00);
    bus(1'h1, ETC_OFS_CLK_SEL, 8'h00);
    bus(1'h1, ETC_OFS_COMPARE, 8'h0f);
    bus(1'h1, ETC_OFS_MODE, 8'h80);
    repeat (3) begin
      ev <= 1'h1;
      repeat (3) @(posedge clk);
      ev <= 1'h0;
      repeat (3) @(posedge clk);
    end
    bus(1'h0, ETC_OFS_COUNT, 8'h00);
    chk("cnt_ev", r, 32'h3);
    bus(1'h1, ETC_OFS_MODE, 8'h00);
    bus(1'h1, ETC_OFS_PORT, 8'h01);
    chk("oe_port", 32'(oe), 32'h0);
    bus(1'h1, ETC_OFS_PORT, 8'h02);
    repeat (3) @(posedge clk);
    chk("pin_latch", 32'({oe, pin}), 32'h3);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    bus(1'h0, ETC_OFS_PORT, 8'h00);
    chk("port_rst", {r[30:0], oe}, 32'h1);
    wrap_up();
  end
endmodule
bind etc_timer etc_timer_monitor i_mon (.SYS_CLK(SYS_CLK), .RST(RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .TIMER_PIN_OE(TIMER_PIN_OE), .IRQ(IRQ));
`default_nettype wire
